// ==== rtl/eeprd_top.sv ====
`timescale 1ns/100ps
module eeprd_top
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // two-wire bus
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // straps and protect state
    input  wire logic [2:0] device_select_pins,
    input  wire logic       permanent_half_protect_flag,
    input  wire logic       reversible_half_protect_flag
);
    import eeprd_pkg::*;

    typedef struct packed {
        eeprd_state_e st;
        eeprd_kind_e  kind;
        logic [7:0]   sh;
        logic [2:0]   cnt;
        logic [7:0]   addr;
        logic         rw;
        logic         ack;
        logic         oe;
        logic [2:0]   pin1;
        logic [2:0]   pin2;
    } eeprd_regs_s;

    eeprd_regs_s r_q;
    eeprd_regs_s r_d;

    logic       sda_lvl;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [7:0] rx_byte;
    logic       mem_we;
    logic [7:0] mem_rd;
    logic [7:0] mem [256];

    // ========================================
    // pin conditioning
    eeprd_pin_sync u_sync (
        .mclk      (mclk),
        .srst      (srst),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_lvl   (sda_lvl),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    assign rx_byte = {r_q.sh[6:0], sda_lvl};
    assign mem_rd  = mem[r_q.addr];

    // lower half is locked by either flag
    function automatic logic write_blocked(input logic [7:0] a);
        write_blocked = ~a[HALF_BIT]
                      & (permanent_half_protect_flag
                         | reversible_half_protect_flag);
    endfunction : write_blocked

    // ========================================
    // protocol engine
    always_comb begin
        r_d      = r_q;
        mem_we   = 1'b0;
        r_d.pin1 = device_select_pins;
        r_d.pin2 = r_q.pin1;
        if (start_det) begin
            // repeated start keeps the counter loaded by a dummy write
            r_d.st   = S_ADDR;
            r_d.cnt  = '0;
            r_d.oe   = 1'b0;
            r_d.kind = K_NONE;
            // a stale ack would fake an address ack on the first fall
            r_d.ack  = 1'b0;
            r_d.sh   = '0;
        end else if (stop_det) begin
            r_d.st = S_IDLE;
            r_d.oe = 1'b0;
        end else begin
            case (r_q.st)
                S_ADDR, S_WORD, S_WDAT: begin
                    if (scl_rise) begin
                        r_d.sh  = rx_byte;
                        r_d.cnt = r_q.cnt + 3'h1;
                        if (r_q.cnt == BIT_LAST) begin
                            r_d.ack = 1'b1;
                            if (r_q.st == S_ADDR) begin
                                r_d.rw   = rx_byte[RW_BIT];
                                r_d.kind = K_NONE;
                                r_d.ack  = 1'b0;
                                if (rx_byte[7:PRE_LSB] == MEM_PREAMBLE &&
                                    rx_byte[3:SEL_LSB] == r_q.pin2) begin
                                    r_d.kind = K_MEM;
                                    r_d.ack  = 1'b1;
                                end else if (rx_byte[7:PRE_LSB] == PROT_PREAMBLE &&
                                             rx_byte[RW_BIT]) begin
                                    // pin match wins over the fixed reversible code
                                    if (rx_byte[3:SEL_LSB] == r_q.pin2) begin
                                        r_d.kind = K_STAT;
                                        r_d.ack  = ~permanent_half_protect_flag;
                                    end else if (rx_byte[3:SEL_LSB] == REV_QUERY_SEL) begin
                                        r_d.kind = K_STAT;
                                        r_d.ack  = ~reversible_half_protect_flag;
                                    end
                                end
                                if (!r_d.ack) begin
                                    // not ours, or a refused status query
                                    r_d.st = S_WAIT;
                                end
                            end else if (r_q.st == S_WORD) begin
                                r_d.addr = rx_byte;
                            end else begin
                                mem_we = ~write_blocked(r_q.addr);
                                // writes roll within the 16-byte page
                                r_d.addr = {r_q.addr[7:4], r_q.addr[3:0] + 4'h1};
                            end
                        end
                    end else if (scl_fall && r_q.cnt == '0 && r_q.ack) begin
                        r_d.oe = 1'b1;
                        r_d.st = (r_q.st == S_ADDR) ? S_AACK
                               : (r_q.st == S_WORD) ? S_WACK : S_DACK;
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        r_d.oe  = 1'b0;
                        r_d.cnt = '0;
                        r_d.ack = 1'b0;
                        if (r_q.kind != K_MEM) begin
                            // status data is don't care, line left released
                            r_d.st = S_WAIT;
                        end else if (r_q.rw) begin
                            r_d.st   = S_RDAT;
                            r_d.sh   = mem_rd;
                            r_d.oe   = ~mem_rd[7];
                            r_d.addr = r_q.addr + 8'h01;
                        end else begin
                            r_d.st = S_WORD;
                            r_d.sh = '0;
                        end
                    end
                end
                S_WACK, S_DACK: begin
                    if (scl_fall) begin
                        r_d.oe  = 1'b0;
                        r_d.cnt = '0;
                        r_d.ack = 1'b0;
                        r_d.sh  = '0;
                        r_d.st  = S_WDAT;
                    end
                end
                S_RDAT: begin
                    if (scl_rise) begin
                        r_d.cnt = r_q.cnt + 3'h1;
                    end else if (scl_fall) begin
                        if (r_q.cnt == '0) begin
                            r_d.oe = 1'b0;
                            r_d.st = S_RACK;
                        end else begin
                            r_d.sh = {r_q.sh[6:0], 1'b0};
                            r_d.oe = ~r_q.sh[6];
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        r_d.ack = ~sda_lvl;
                    end else if (scl_fall) begin
                        if (r_q.ack) begin
                            // counter rolls 0xff to 0x00 with no gap
                            r_d.st   = S_RDAT;
                            r_d.sh   = mem_rd;
                            r_d.oe   = ~mem_rd[7];
                            r_d.addr = r_q.addr + 8'h01;
                            r_d.cnt  = '0;
                        end else begin
                            r_d.st = S_WAIT;
                        end
                        r_d.ack = 1'b0;
                    end
                end
                S_WAIT, S_IDLE: begin
                    r_d.oe = 1'b0;
                end
                default: begin
                    r_d.st = S_IDLE;
                    r_d.oe = 1'b0;
                end
            endcase
        end
    end

    // counter survives reset-free between frames; only srst clears it
    always_ff @(posedge mclk) begin
        if (srst) begin
            r_q      <= '0;
            r_q.st   <= S_IDLE;
            r_q.kind <= K_NONE;
            r_q.addr <= ADDR_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // array content is not reset, as in a real nonvolatile part
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[r_q.addr] <= rx_byte;
        end
    end

    assign sda_o  = SDA_DRIVE_LVL;
    assign sda_oe = r_q.oe;

endmodule : eeprd_top

// ==== rtl/eeprd_pkg.sv ====
package eeprd_pkg;

    // ========================================
    // command bytes
    localparam logic [3:0] MEM_PREAMBLE  = 4'ha;
    localparam logic [3:0] PROT_PREAMBLE = 4'h6;
    localparam logic [2:0] REV_QUERY_SEL = 3'h1;
    localparam int         RW_BIT        = 0;
    localparam int         SEL_LSB       = 1;
    localparam int         PRE_LSB       = 4;
    localparam int         HALF_BIT      = 7;

    // ========================================
    // reset values and sizes
    localparam logic [7:0] ADDR_RESET    = 8'h00;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic       SDA_DRIVE_LVL = 1'b0;

    // ========================================
    // command kinds
    typedef enum logic [1:0] {
        K_NONE = 2'h0,
        K_MEM  = 2'h1,
        K_STAT = 2'h2
    } eeprd_kind_e;

    // ========================================
    // protocol states, gray along the write path; AACK to RDAT flips three bits
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_AACK = 4'h3,
        S_WORD = 4'h2,
        S_WACK = 4'h6,
        S_WDAT = 4'h7,
        S_DACK = 4'h5,
        S_RDAT = 4'h4,
        S_RACK = 4'hc,
        S_WAIT = 4'hd
    } eeprd_state_e;

endpackage : eeprd_pkg

// ==== rtl/eeprd_pin_sync.sv ====
`timescale 1ns/100ps
module eeprd_pin_sync
    import eeprd_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // raw bus pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    // conditioned bus events
    output logic      sda_lvl,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } eeprd_sync_s;

    eeprd_sync_s r_q;
    eeprd_sync_s r_d;

    // ========================================
    // two flops, then a third for edges
    always_comb begin
        r_d    = r_q;
        r_d.s1 = {scl_i, sda_i};
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
    end

    // idle bus reads high on both lines
    always_ff @(posedge mclk) begin
        if (srst) begin
            r_q <= '1;
        end else begin
            r_q <= r_d;
        end
    end

    assign sda_lvl   = r_q.s2[0];
    assign scl_rise  = r_q.s2[1] & ~r_q.s3[1];
    assign scl_fall  = ~r_q.s2[1] & r_q.s3[1];
    assign start_det = r_q.s2[1] & r_q.s3[1] & ~r_q.s2[0] & r_q.s3[0];
    assign stop_det  = r_q.s2[1] & r_q.s3[1] & r_q.s2[0] & ~r_q.s3[0];

endmodule : eeprd_pin_sync

// ==== testbench/eeprd_top_assertions.sv ====
`timescale 1ns/100ps
module eeprd_top_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe
);
    // ========================================
    // bus drive timing
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    AST_DRIVE_LOW: assert property (sda_o == 1'b0)
        else $error("sda drive level not low");
    AST_RESET_QUIET: assert property ($fell(srst) |-> !sda_oe [*3])
        else $error("sda driven right after reset");
    AST_CHANGE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("sda drive changed while scl high");
    AST_HOLD_BIT: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*4])
        else $error("sda drive not held for a bit time");
    AST_RELEASE_SCL_LOW: assert property ($fell(sda_oe) |-> !scl_i && !$past(scl_i))
        else $error("sda released outside scl low");
    AST_STOP_QUIET: assert property ($rose(sda_i) && scl_i |-> !sda_oe [*8])
        else $error("sda driven after stop");
    AST_START_QUIET: assert property ($fell(sda_i) && scl_i |-> !sda_oe [*8])
        else $error("sda driven during address after start");
    AST_HIGH_STABLE: assert property (scl_i && !$past(scl_i) |-> $stable(sda_oe) [*3])
        else $error("sda drive moved in scl high phase");
    // ========================================
    // main scenarios
    cover property ($rose(sda_oe));
    cover property ($fell(sda_i) && scl_i);
    cover property ($rose(sda_i) && scl_i);
endmodule : eeprd_top_chk

// ==== testbench/eeprd_host_model.sv ====
`timescale 1ns/100ps
module eeprd_host_model (
    // clock and wire
    input  wire logic mclk,
    input  wire logic sda_wire,
    // host drive
    output logic      scl,
    output logic      sda_pull
);
    // ========================================
    // bit cycles; scl stands high outside frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask : wt
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        wt(2);
        scl = 1'b1;
        wt(3);
        r = sda_wire;
        wt(1);
        scl = 1'b0;
        wt(2);
    endtask : bit_io
    // release first so it also serves as repeated start
    task automatic start();
        sda_pull = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_pull = 1'b1;
        wt(4);
        scl = 1'b0;
        wt(2);
    endtask : start
    task automatic stop();
        sda_pull = 1'b1;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_pull = 1'b0;
        wt(4);
    endtask : stop
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : tx
    task automatic rx(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~more, r);
    endtask : rx
endmodule : eeprd_host_model

// ==== testbench/eeprd_top_test.sv ====
`timescale 1ns/100ps
module eeprd_top_test;
    import eeprd_pkg::*;
    localparam logic [2:0] PINS  = 3'h5;
    localparam logic [7:0] DEV_W = {4'ha, PINS, 1'b0};
    localparam logic [7:0] DEV_R = {4'ha, PINS, 1'b1};
    logic mclk, srst, perm, rev, scl, sda_pull, sda_o, sda_oe;
    wire  sda_wire;
    int   error_cnt, compares, cycles;
    // pulled-up wire, either party may pull low
    assign sda_wire = ~(sda_pull | sda_oe);
    eeprd_host_model host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
    eeprd_top uut (.mclk(mclk), .srst(srst), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
        .sda_oe(sda_oe), .device_select_pins(PINS), .permanent_half_protect_flag(perm),
        .reversible_half_protect_flag(rev));
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;
    // ========================================
    // checking and closing
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("counts: %0d mismatches in %0d compares", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // ========================================
    // bus transactions
    task automatic txa(input logic [7:0] d, input logic e);
        logic k;
        host.tx(d, k);
        chk({7'h00, k}, {7'h00, e});
    endtask : txa
    task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
        host.start();
        txa(DEV_W, 1'b1);
        txa(a, 1'b1);
        txa(d0, 1'b1);
        txa(d1, 1'b1);
        host.stop();
    endtask : wr
    task automatic dummy(input logic [7:0] a);
        host.start();
        txa(DEV_W, 1'b1);
        txa(a, 1'b1);
    endtask : dummy
    task automatic rdcur(input int n, input logic [7:0] e [4]);
        logic [7:0] d;
        host.start();
        txa(DEV_R, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.rx(i < n - 1, d);
            chk(d, e[i]);
        end
        host.stop();
        host.wt(8);
        chk({7'h00, sda_oe}, 8'h00);
    endtask : rdcur
    // ========================================
    // scenarios
    task automatic t_seq_wrap();
        wr(8'hfe, 8'h5a, 8'ha5);
        wr(8'h00, 8'h3c, 8'hc3);
        dummy(8'hfe);
        rdcur(4, '{8'h5a, 8'ha5, 8'h3c, 8'hc3});
    endtask : t_seq_wrap
    task automatic t_cur_wrap();
        dummy(8'hff);
        rdcur(1, '{8'ha5, 8'h00, 8'h00, 8'h00});
        rdcur(1, '{8'h3c, 8'h00, 8'h00, 8'h00});
        rdcur(1, '{8'hc3, 8'h00, 8'h00, 8'h00});
    endtask : t_cur_wrap
    task automatic t_status();
        for (int i = 0; i < 4; i++) begin
            {perm, rev} = i[1:0];
            host.start();
            txa({4'h6, PINS, 1'b1}, ~perm);
            host.start();
            txa({4'h6, 3'h1, 1'b1}, ~rev);
            host.stop();
        end
        {perm, rev} = 2'h0;
        host.start();
        txa({4'h6, 3'h3, 1'b1}, 1'b0);
        host.start();
        txa({4'ha, 3'h3, 1'b1}, 1'b0);
        host.stop();
    endtask : t_status
    task automatic t_protect();
        for (int i = 1; i < 3; i++) begin
            {perm, rev} = i[1:0];
            wr(8'h00, 8'hff, 8'hee);
        end
        {perm, rev} = 2'h3;
        wr(8'hfe, 8'h77, 8'h66);
        {perm, rev} = 2'h0;
        dummy(8'h00);
        rdcur(2, '{8'h3c, 8'hc3, 8'h00, 8'h00});
        dummy(8'hfe);
        rdcur(2, '{8'h77, 8'h66, 8'h00, 8'h00});
    endtask : t_protect
    initial begin
        srst = 1'b1;
        perm = 1'b0;
        rev = 1'b0;
        error_cnt = 0;
        compares = 0;
        cycles = 0;
        repeat (12) @(negedge mclk);
        srst = 1'b0;
        host.wt(4);
        t_seq_wrap();
        t_cur_wrap();
        t_status();
        t_protect();
        close_out();
    end
endmodule : eeprd_top_test

bind eeprd_top eeprd_top_chk chk_i (.mclk(mclk), .srst(srst), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe));
